// *** verilog/hfe_pkg.sv ***
// Shared constants for the function endpoint 0 transmit and interrupt mask registers
package hfe_pkg;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned IRQ_W         = 5;
  localparam int unsigned DEV_ADDR_W    = 7;
  localparam int unsigned TX_CNT_W      = 4;
  localparam int unsigned FIFO_DEPTH    = 8;

  // Register offsets on the register access port
  localparam logic [7:0] OFS_INT_MASK   = 8'h01;
  localparam logic [7:0] OFS_FUNC_ADDR  = 8'h02;
  localparam logic [7:0] OFS_TX_FIFO    = 8'h03;
  localparam logic [7:0] OFS_TX_CNT     = 8'h04;

  // Interrupt mask field positions
  localparam int unsigned MSK_EP_ZERO_TX_BIT = 0;
  localparam int unsigned MSK_EP_ZERO_RX_BIT = 1;
  localparam int unsigned MSK_EP_ONE_TX_BIT  = 2;
  localparam int unsigned MSK_RST_BIT        = 3;
  localparam int unsigned MSK_SUSP_BIT       = 4;

  // Function address field positions
  localparam int unsigned PORT_EN_BIT   = 7;
  localparam int unsigned DEV_ADDR_LSB  = 0;

  // Reset values
  localparam logic [4:0] RST_INT_MASK   = 5'h00;
  localparam logic [6:0] RST_DEV_ADDR   = 7'h00;
  localparam logic       RST_PORT_EN    = 1'b0;
  localparam logic [3:0] RST_TX_CNT     = 4'h0;
  localparam logic [7:0] RD_ZERO        = 8'h00;
endpackage : hfe_pkg

// *** verilog/hfe_skid_buf.sv ***
// Two-entry valid/ready buffer between the data port and the transmit FIFO
`timescale 1ns/1ps
module hfe_skid_buf #(
  parameter int unsigned W = 8
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         clear_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  logic [W-1:0] d0_q;
  logic [W-1:0] d1_q;
  logic [1:0]   cnt_q;
  logic [1:0]   cnt_d;
  logic         space_q;
  logic         push;
  logic         pop;

  assign push        = in_valid_i & space_q;
  assign pop         = out_valid_o & out_ready_i;
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = d0_q;
  // Ready comes from a flop so the writer never sees a combinational path
  assign in_ready_o  = space_q;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || clear_i) begin
      cnt_q   <= 2'h0;
      space_q <= 1'b1;
    end else begin
      cnt_q   <= cnt_d;
      space_q <= (cnt_d != 2'h2);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push && pop) begin
      if (cnt_q == 2'h1) begin
        d0_q <= in_data_i;
      end else begin
        d0_q <= d1_q;
        d1_q <= in_data_i;
      end
    end else if (push) begin
      if (cnt_q == 2'h0) begin
        d0_q <= in_data_i;
      end else begin
        d1_q <= in_data_i;
      end
    end else if (pop) begin
      d0_q <= d1_q;
    end
  end
endmodule : hfe_skid_buf

// *** verilog/hfe_tx_fifo.sv ***
// Endpoint 0 transmit FIFO storage with clearable pointers
`timescale 1ns/1ps
module hfe_tx_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         clear_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wptr_q;
  logic [AW:0]  rptr_q;
  logic         full;
  logic         empty;

  assign empty       = (wptr_q == rptr_q);
  assign full        = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem_q[rptr_q[AW-1:0]];

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || clear_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (in_valid_i && !full) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (out_ready_i && !empty) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (in_valid_i && !full) begin
      mem_q[wptr_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule : hfe_tx_fifo

// *** verilog/hfe_ep0_regs.sv ***
// What this block does
// - Mask bit 4 enables suspend interrupt, reset clears
// - Mask bit 3 enables port reset interrupt
// - Mask bit 2 enables endpoint 1 transmit interrupt
// - Mask bit 1 enables endpoint 0 receive interrupt
// - Mask bit 0 enables endpoint 0 transmit interrupt
// - Set port feature sets read-only enabled flag
// - Set Address request loads device address field
// - Address field read/write, cleared at reset
// - Write-only data port pushes one byte
// - Byte count write arms the transmit FIFO
// - Byte count never decrements while sending
// - Byte count read/write, cleared at reset
// - Interrupt output follows unmasked pending bits
// - Armed FIFO sent on next IN token
`timescale 1ns/1ps
module hfe_ep0_regs #(
  parameter int unsigned FIFO_DEPTH = hfe_pkg::FIFO_DEPTH
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  // Register access port from the local controller's serial slave
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic [7:0]      reg_rdata_o,
  output logic            fifo_wr_ready_o,
  // Interrupt status from the function interface
  input  wire logic [4:0] irq_status_i,
  output logic            irq_o,
  // Enumeration events from the function control logic
  input  wire logic       set_addr_i,
  input  wire logic [6:0] set_addr_val_i,
  input  wire logic       set_port_feature_i,
  output logic [6:0]      device_address_o,
  output logic            port_enabled_flag_o,
  // Endpoint 0 transmit engine side
  input  wire logic       in_token_i,
  input  wire logic       tx_ack_i,
  input  wire logic       setup_rcvd_i,
  input  wire logic       tx_fifo_clear_i,
  output logic            tx_fifo_arm_o,
  output logic            tx_valid_o,
  input  wire logic       tx_ready_i,
  output logic [7:0]      tx_data_o,
  output logic            tx_last_o,
  output logic            tx_zlp_o,
  output logic            tx_nak_o,
  output logic            tx_underrun_o
);
  typedef enum logic [0:0] {
    HFE_IDLE = 1'b0,
    HFE_SEND = 1'b1
  } hfe_state_t;

  hfe_state_t  state_q;
  logic [4:0]  int_mask_q;
  logic [6:0]  device_address_field_q;
  logic        port_enabled_flag_q;
  logic [3:0]  tx_byte_count_field_q;
  logic        tx_fifo_arm_q;
  logic [3:0]  remain_q;
  logic [7:0]  rdata_q;
  logic        irq_q;
  logic        tx_valid_q;
  logic [7:0]  tx_data_q;
  logic        tx_last_q;
  logic        tx_zlp_q;
  logic        tx_nak_q;
  logic        tx_underrun_q;

  logic        buf_push;
  logic        buf_ready;
  logic        buf_out_valid;
  logic [7:0]  buf_out_data;
  logic        fifo_in_ready;
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic        fifo_pop;
  logic        slot_free;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  logic wr_mask;
  logic wr_addr;
  logic wr_fifo;
  logic wr_count;

  assign wr_mask   = reg_wr_i && hit(reg_addr_i, hfe_pkg::OFS_INT_MASK);
  assign wr_addr   = reg_wr_i && hit(reg_addr_i, hfe_pkg::OFS_FUNC_ADDR);
  assign wr_fifo   = reg_wr_i && hit(reg_addr_i, hfe_pkg::OFS_TX_FIFO);
  assign wr_count  = reg_wr_i && hit(reg_addr_i, hfe_pkg::OFS_TX_CNT);
  assign buf_push  = wr_fifo;
  assign slot_free = !tx_valid_q || tx_ready_i;
  assign fifo_pop  = (state_q == HFE_SEND) && slot_free && (remain_q != 4'h0) && fifo_valid;

  // Only the mask field is stored, upper bits are dropped on write
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      int_mask_q <= hfe_pkg::RST_INT_MASK;
    end else if (wr_mask) begin
      int_mask_q <= reg_wdata_i[4:0];
    end
  end

  // Host's Set Address wins over a firmware write in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      device_address_field_q <= hfe_pkg::RST_DEV_ADDR;
    end else if (set_addr_i) begin
      device_address_field_q <= set_addr_val_i;
    end else if (wr_addr) begin
      device_address_field_q <= reg_wdata_i[6:0];
    end
  end

  // Read-only: firmware writes to bit 7 are ignored
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      port_enabled_flag_q <= hfe_pkg::RST_PORT_EN;
    end else if (set_port_feature_i) begin
      port_enabled_flag_q <= 1'b1;
    end
  end

  // Only firmware writes change the count; transmission never touches it
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      tx_byte_count_field_q <= hfe_pkg::RST_TX_CNT;
    end else if (wr_count) begin
      tx_byte_count_field_q <= reg_wdata_i[3:0];
    end
  end

  // Arm set wins over any clear arriving in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      tx_fifo_arm_q <= 1'b0;
    end else if (wr_count) begin
      tx_fifo_arm_q <= 1'b1;
    end else if (tx_ack_i || setup_rcvd_i || tx_fifo_clear_i) begin
      tx_fifo_arm_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_i & int_mask_q);
    end
  end

  // Registered read data keeps the serial slave free of a long decode path
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rdata_q <= hfe_pkg::RD_ZERO;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        hfe_pkg::OFS_INT_MASK:  rdata_q <= {3'h0, int_mask_q};
        hfe_pkg::OFS_FUNC_ADDR: rdata_q <= {port_enabled_flag_q, device_address_field_q};
        hfe_pkg::OFS_TX_CNT:    rdata_q <= {4'h0, tx_byte_count_field_q};
        default:                rdata_q <= hfe_pkg::RD_ZERO;
      endcase
    end
  end

  // Transmit engine: a private down-counter leaves the byte count intact
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || tx_fifo_clear_i) begin
      state_q       <= HFE_IDLE;
      remain_q      <= 4'h0;
      tx_valid_q    <= 1'b0;
      tx_data_q     <= 8'h00;
      tx_last_q     <= 1'b0;
      tx_zlp_q      <= 1'b0;
      tx_nak_q      <= 1'b0;
      tx_underrun_q <= 1'b0;
    end else begin
      tx_zlp_q      <= 1'b0;
      tx_nak_q      <= 1'b0;
      tx_underrun_q <= 1'b0;
      unique case (state_q)
        HFE_IDLE: begin
          if (tx_valid_q && tx_ready_i) begin
            tx_valid_q <= 1'b0;
            tx_last_q  <= 1'b0;
          end
          if (in_token_i) begin
            if (!tx_fifo_arm_q) begin
              tx_nak_q <= 1'b1;
            end else if (tx_byte_count_field_q == 4'h0) begin
              tx_zlp_q <= 1'b1;
            end else begin
              state_q  <= HFE_SEND;
              remain_q <= tx_byte_count_field_q;
            end
          end
        end
        HFE_SEND: begin
          if (slot_free) begin
            if (remain_q == 4'h0) begin
              tx_valid_q <= 1'b0;
              tx_last_q  <= 1'b0;
              state_q    <= HFE_IDLE;
            end else if (fifo_valid) begin
              tx_valid_q <= 1'b1;
              tx_data_q  <= fifo_data;
              tx_last_q  <= (remain_q == 4'h1);
              remain_q   <= remain_q - 4'h1;
            end else begin
              // FIFO ran dry before the count was reached
              tx_valid_q    <= 1'b0;
              tx_last_q     <= 1'b0;
              tx_underrun_q <= 1'b1;
              state_q       <= HFE_IDLE;
            end
          end
        end
      endcase
    end
  end

  hfe_skid_buf #(
    .W (hfe_pkg::DATA_W)
  ) u_buf (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .clear_i     (tx_fifo_clear_i),
    .in_valid_i  (buf_push),
    .in_ready_o  (buf_ready),
    .in_data_i   (reg_wdata_i),
    .out_valid_o (buf_out_valid),
    .out_ready_i (fifo_in_ready),
    .out_data_o  (buf_out_data)
  );

  hfe_tx_fifo #(
    .W     (hfe_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .clear_i     (tx_fifo_clear_i),
    .in_valid_i  (buf_out_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (buf_out_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  assign reg_rdata_o         = rdata_q;
  assign fifo_wr_ready_o     = buf_ready;
  assign irq_o               = irq_q;
  assign device_address_o    = device_address_field_q;
  assign port_enabled_flag_o = port_enabled_flag_q;
  assign tx_fifo_arm_o       = tx_fifo_arm_q;
  assign tx_valid_o          = tx_valid_q;
  assign tx_data_o           = tx_data_q;
  assign tx_last_o           = tx_last_q;
  assign tx_zlp_o            = tx_zlp_q;
  assign tx_nak_o            = tx_nak_q;
  assign tx_underrun_o       = tx_underrun_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  chk_mask_susp_bit: assert property (
    wr_mask |=> int_mask_q[hfe_pkg::MSK_SUSP_BIT] == $past(reg_wdata_i[4]))
    else $error("Suspend mask bit not written");
  chk_mask_rst_bit: assert property (
    wr_mask |=> int_mask_q[hfe_pkg::MSK_RST_BIT] == $past(reg_wdata_i[3]))
    else $error("Port reset mask bit not written");
  chk_ep1_tx_mask: assert property (
    wr_mask ##1 !wr_mask |=> int_mask_q[hfe_pkg::MSK_EP_ONE_TX_BIT] == $past(reg_wdata_i[2], 2))
    else $error("Endpoint 1 transmit mask bit lost");
  chk_ep0_rx_mask: assert property (
    wr_mask |=> int_mask_q[hfe_pkg::MSK_EP_ZERO_RX_BIT] == $past(reg_wdata_i[1]))
    else $error("Endpoint 0 receive mask bit not written");
  chk_ep0_tx_mask: assert property (
    !wr_mask |=> $stable(int_mask_q[hfe_pkg::MSK_EP_ZERO_TX_BIT]))
    else $error("Endpoint 0 transmit mask changed without a write");
  chk_port_enable_set: assert property (
    set_port_feature_i |=> port_enabled_flag_o [*2])
    else $error("Port enabled flag not set");
  chk_set_addr_load: assert property (
    set_addr_i |=> device_address_o == $past(set_addr_val_i))
    else $error("Set Address did not load the address");
  chk_mcu_addr_write: assert property (
    wr_addr && !set_addr_i |=> device_address_o == $past(reg_wdata_i[6:0]))
    else $error("Firmware address write lost");
  chk_arm_on_count: assert property (
    wr_count |=> tx_fifo_arm_o)
    else $error("Byte count write did not arm the FIFO");
  chk_count_holds: assert property (
    state_q == HFE_SEND && !wr_count |=> $stable(tx_byte_count_field_q))
    else $error("Byte count changed while sending");
  chk_irq_follows: assert property (
    |(irq_status_i & int_mask_q) |=> irq_o)
    else $error("Unmasked pending bit without interrupt");
  chk_irq_masked: assert property (
    !(|(irq_status_i & int_mask_q)) |=> !irq_o)
    else $error("Interrupt raised with nothing unmasked");
  chk_send_on_in: assert property (
    state_q == HFE_IDLE && in_token_i && tx_fifo_arm_o && tx_byte_count_field_q != 4'h0
      && !tx_fifo_clear_i |=> state_q == HFE_SEND)
    else $error("Armed FIFO not sent on IN token");
  chk_reserved_zero: assert property (
    reg_rd_i && (hit(reg_addr_i, hfe_pkg::OFS_INT_MASK) || hit(reg_addr_i, hfe_pkg::OFS_TX_CNT))
      |=> reg_rdata_o[7:5] == 3'h0)
    else $error("Reserved bits read non-zero");

  // Endpoint 0 transmit mask write, arm clearing, transmit outcomes and count reserved bits; a count write in the same cycle wins over clearing
  chk_ep0_tx_write: assert property (
    wr_mask |=> int_mask_q[hfe_pkg::MSK_EP_ZERO_TX_BIT] == $past(reg_wdata_i[0]))
    else $error("Endpoint 0 transmit mask bit not written");
  chk_arm_clears: assert property (
    (tx_ack_i || setup_rcvd_i || tx_fifo_clear_i) && !wr_count |=> !tx_fifo_arm_o)
    else $error("Arm not dropped by acknowledge, setup or clear");
  chk_nak_unarmed: assert property (
    state_q == HFE_IDLE && in_token_i && !tx_fifo_arm_o && !tx_fifo_clear_i |=> tx_nak_o)
    else $error("IN token while unarmed gave no NAK");
  chk_zlp_zero_count: assert property (
    state_q == HFE_IDLE && in_token_i && tx_fifo_arm_o && tx_byte_count_field_q == 4'h0
      && !tx_fifo_clear_i |=> tx_zlp_o)
    else $error("Armed zero count gave no zero-length packet");
  chk_count_reserved: assert property (
    reg_rd_i && hit(reg_addr_i, hfe_pkg::OFS_TX_CNT) |=> reg_rdata_o[7:4] == 4'h0)
    else $error("Byte count reserved bits read non-zero");

  cov_full_packet: cover property (tx_valid_o && tx_last_o && tx_ready_i);
  cov_nak_unarmed: cover property (tx_nak_o);
  cov_buffer_full: cover property (wr_fifo && !fifo_wr_ready_o);
  cov_irq_raise:   cover property (!irq_o ##1 irq_o);
  cov_zero_length: cover property (tx_zlp_o);
endmodule : hfe_ep0_regs

// *** testbench/hfe_host_model.sv ***
// Host-side sink that issues IN tokens and drains the endpoint 0 byte stream
`timescale 1ns/1ps
module hfe_host_model (
  input  wire logic       sys_clk_i,
  output logic            in_token_o,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_last_i,
  input  wire logic       tx_nak_i
);
  logic [7:0] got_q[$];
  logic       last_q[$];

  initial begin
    in_token_o = 1'b0;
    tx_ready_o = 1'b0;
  end

  // Ready toggles so every byte after the first meets a stall; sampling at the falling edge avoids races
  task automatic take(input int n, output int naks);
    logic v;
    got_q.delete();
    last_q.delete();
    naks = 0;
    @(posedge sys_clk_i);
    in_token_o <= 1'b1;
    @(posedge sys_clk_i);
    in_token_o <= 1'b0;
    for (int c = 0; c < 200 && (got_q.size() < n || c < 4); c++) begin
      tx_ready_o <= c[0];
      @(negedge sys_clk_i);
      v = (tx_valid_i === 1'b1) && (tx_ready_o === 1'b1);
      naks += int'(tx_nak_i === 1'b1);
      if (v) begin
        got_q.push_back(tx_data_i);
        last_q.push_back(tx_last_i);
      end
      @(posedge sys_clk_i);
    end
    tx_ready_o <= 1'b0;
  endtask : take
endmodule : hfe_host_model

// *** testbench/hfe_ep0_regs_tb.sv ***
// Self-checking bench for the endpoint 0 transmit and interrupt mask registers
`timescale 1ns/1ps
module hfe_ep0_regs_tb;
  logic       sys_clk_i, rstn_i, reg_wr_i, reg_rd_i, fifo_wr_ready_o, irq_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, tx_data_o;
  logic [4:0] irq_status_i;
  logic [6:0] set_addr_val_i, device_address_o;
  logic       set_addr_i, set_port_feature_i, port_enabled_flag_o, in_token_i;
  logic       tx_ack_i, setup_rcvd_i, tx_fifo_clear_i, tx_fifo_arm_o;
  logic       tx_valid_o, tx_ready_i, tx_last_o, tx_nak_o, tx_zlp_o, tx_underrun_o;
  int         fail_count, comparisons, cycles, k, naks, zlps, underruns;

  hfe_ep0_regs dut_u (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .fifo_wr_ready_o(fifo_wr_ready_o), .irq_status_i(irq_status_i), .irq_o(irq_o),
    .set_addr_i(set_addr_i), .set_addr_val_i(set_addr_val_i),
    .set_port_feature_i(set_port_feature_i), .device_address_o(device_address_o),
    .port_enabled_flag_o(port_enabled_flag_o), .in_token_i(in_token_i),
    .tx_ack_i(tx_ack_i), .setup_rcvd_i(setup_rcvd_i), .tx_fifo_clear_i(tx_fifo_clear_i),
    .tx_fifo_arm_o(tx_fifo_arm_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_zlp_o(tx_zlp_o), .tx_nak_o(tx_nak_o),
    .tx_underrun_o(tx_underrun_o)
  );

  hfe_host_model host_u (
    .sys_clk_i(sys_clk_i), .in_token_o(in_token_i), .tx_valid_i(tx_valid_o),
    .tx_ready_o(tx_ready_i), .tx_data_i(tx_data_o), .tx_last_i(tx_last_o),
    .tx_nak_i(tx_nak_o)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // Normal tests take a few hundred cycles
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      results();
    end
  end

  // Zero-length and underrun pulses are tallied at every rising edge so no scenario can miss them
  always @(posedge sys_clk_i) begin
    zlps      <= zlps + int'(tx_zlp_o === 1'b1);
    underruns <= underruns + int'(tx_underrun_o === 1'b1);
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    #1 chk(n, e, reg_rdata_o);
  endtask : rd

  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, set_addr_i, set_port_feature_i} = '0;
    {tx_ack_i, setup_rcvd_i, tx_fifo_clear_i} = '0;
    {reg_addr_i, reg_wdata_i, irq_status_i, set_addr_val_i} = '0;
    {fail_count, comparisons, cycles, k, naks} = '0;
    repeat (12) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    #1 chk("buffer ready", 8'h01, {7'h0, fifo_wr_ready_o});
    // Offsets 5 to 7 are unmapped; the data port reads zero
    for (int a = 1; a < 8; a++) begin
      rd(8'(a), 8'h00, "reset value");
    end
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h1f, "mask reserved");
    wr(8'h07, 8'h00);
    rd(8'h01, 8'h1f, "mask after unmapped write");
    // Each mask bit lets its own status bit through and no other
    for (int b = 0; b < 5; b++) begin
      wr(8'h01, 8'h01 << b);
      rd(8'h01, 8'h01 << b, "mask readback");
      @(posedge sys_clk_i);
      irq_status_i <= 5'h01 << b;
      repeat (2) @(posedge sys_clk_i);
      #1 chk("irq unmasked", 8'h01, {7'h0, irq_o});
      @(posedge sys_clk_i);
      irq_status_i <= 5'h1f ^ (5'h01 << b);
      repeat (2) @(posedge sys_clk_i);
      #1 chk("irq masked", 8'h00, {7'h0, irq_o});
    end
    wr(8'h01, 8'h00);
    wr(8'h02, 8'hff);
    rd(8'h02, 8'h7f, "address write");
    @(posedge sys_clk_i);
    set_addr_i     <= 1'b1;
    set_addr_val_i <= 7'h2a;
    @(posedge sys_clk_i);
    set_addr_i <= 1'b0;
    @(posedge sys_clk_i);
    #1 chk("device address", 8'h2a, {1'b0, device_address_o});
    rd(8'h02, 8'h2a, "address loaded");
    @(posedge sys_clk_i);
    set_port_feature_i <= 1'b1;
    @(posedge sys_clk_i);
    set_port_feature_i <= 1'b0;
    rd(8'h02, 8'haa, "port enabled");
    chk("port flag", 8'h01, {7'h0, port_enabled_flag_o});
    // Fill FIFO and buffer until refused; the refused byte must not appear
    for (int i = 0; i < 16 && fifo_wr_ready_o === 1'b1; i++) begin
      wr(8'h03, 8'h40 + 8'(k));
      @(posedge sys_clk_i);
      k++;
    end
    chk("buffer full", 8'h00, {7'h0, fifo_wr_ready_o});
    chk("capacity", 8'(hfe_pkg::FIFO_DEPTH + 2), 8'(k));
    wr(8'h03, 8'hee);
    wr(8'h04, 8'(k));
    @(posedge sys_clk_i);
    #1 chk("arm on count", 8'h01, {7'h0, tx_fifo_arm_o});
    rd(8'h04, 8'(k), "count readback");
    host_u.take(k, naks);
    chk("packet length", 8'(k), 8'(host_u.got_q.size()));
    chk("no nak", 8'h00, 8'(naks));
    for (int i = 0; i < host_u.got_q.size(); i++) begin
      chk("byte", 8'h40 + 8'(i), host_u.got_q[i]);
      chk("last", {7'h0, i == k - 1}, {7'h0, host_u.last_q[i]});
    end
    rd(8'h04, 8'(k), "count after send");
    chk("drained", 8'h01, {7'h0, fifo_wr_ready_o});
    // Acknowledge, new setup and clear each drop the arm
    for (int j = 0; j < 3; j++) begin
      wr(8'h04, 8'h00);
      @(posedge sys_clk_i);
      #1 chk("arm zero count", 8'h01, {7'h0, tx_fifo_arm_o});
      @(posedge sys_clk_i);
      {tx_ack_i, setup_rcvd_i, tx_fifo_clear_i} <= 3'b100 >> j;
      @(posedge sys_clk_i);
      {tx_ack_i, setup_rcvd_i, tx_fifo_clear_i} <= 3'b000;
      @(posedge sys_clk_i);
      #1 chk("arm cleared", 8'h00, {7'h0, tx_fifo_arm_o});
    end
    host_u.take(0, naks);
    chk("nak when idle", 8'h01, 8'(naks));
    wr(8'h04, 8'hf2);
    rd(8'h04, 8'h02, "count reserved");
    chk("arm on count", 8'h01, {7'h0, tx_fifo_arm_o});
    // FIFO was flushed, so an armed count of 2 must abort as an underrun
    host_u.take(0, naks);
    chk("underrun", 8'h01, 8'(underruns));
    chk("no nak when armed", 8'h00, 8'(naks));
    wr(8'h04, 8'h00);
    host_u.take(0, naks);
    chk("zero length", 8'h01, 8'(zlps));
    results();
  end
endmodule : hfe_ep0_regs_tb
